//--- core/flash_cfg_pkg.sv
// Shared constants and carrier types for the flash security and configuration registers.
// Assumes a 32-bit AHB-Lite register port and an 8-bit register file in the low byte lanes.
package flash_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CMD_INDEX_IDX   = 8'h02;
  localparam logic [7:0] ECC_INDEX_IDX   = 8'h03;
  localparam logic [7:0] FLASH_CFG_IDX   = 8'h04;
  localparam logic [7:0] SECURITY_IDX    = 8'h01;
  localparam logic [7:0] MAIN_STATUS_IDX = 8'h06;
  localparam logic [7:0] ERR_CFG_IDX     = 8'h07;
  localparam logic [7:0] ERR_STATUS_IDX  = 8'h08;

  // Security field layout
  localparam int KEY_EN_MSB   = 7;
  localparam int KEY_EN_LSB   = 6;
  localparam int SEC_MSB      = 1;
  localparam int SEC_LSB      = 0;
  localparam logic [1:0] KEY_ENABLED_CODE = 2'h2;
  localparam logic [1:0] UNSECURED_CODE   = 2'h2;
  localparam logic [7:0] SECURITY_FAULT_VALUE = 8'hff;
  localparam logic [22:0] SECURITY_BYTE_ADDR  = 23'h7fff0f;

  // Index and configuration layouts
  localparam int CMD_INDEX_WIDTH = 3;
  localparam int ECC_INDEX_WIDTH = 3;
  localparam int CMD_DONE_IE_BIT = 7;
  localparam int IGNORE_SF_BIT   = 4;
  localparam int FORCE_DF_BIT    = 1;
  localparam int FORCE_SF_BIT    = 0;
  localparam logic [7:0] FLASH_CFG_MASK = 8'h93;
  localparam int CMD_DONE_BIT    = 7;
  localparam int DF_BIT          = 1;
  localparam int SF_BIT          = 0;

  // Reset values
  localparam logic [7:0] SECURITY_RESET = 8'hff;
  localparam logic [7:0] FLASH_CFG_RESET = 8'h00;
  localparam logic [7:0] ERR_CFG_RESET   = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  index;
  } bus_req_type;

  // Array read outcome reported by the read path
  typedef struct packed {
    logic        strobe;
    logic        singleFault;
    logic        doubleFault;
  } read_event_type;

  typedef enum logic [1:0] {
    LOAD_WAIT,
    LOAD_RUN,
    LOAD_DONE
  } load_state_type;

endpackage

//--- core/flash_cfg_bit_flag.sv
// Sticky status flag with set over clear priority and a gated level request.
// Assumes set and clear arrive on the same clock as the flag.
`timescale 1ns/1ns
`default_nettype none
module flash_cfg_bit_flag (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic setEvent,
  input  wire logic clearEvent,
  input  wire logic enable,
  output logic      flag,
  output logic      request
);
  typedef struct packed {
    logic flag;
  } flag_state_type;

  flag_state_type state_reg;
  flag_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (clearEvent) begin
      state_next.flag = 1'b0;
    end
    if (setEvent) begin
      state_next.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag    = state_reg.flag;
  assign request = state_reg.flag & enable;

  property p_req_level;
    @(posedge sys_clk) disable iff (rst)
    request == (flag && enable);
  endproperty
  a_req_level: assert property (p_req_level) else $error("request not flag and enable");
  property p_set_wins;
    @(posedge sys_clk) disable iff (rst)
    setEvent |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");
  property p_clear;
    @(posedge sys_clk) disable iff (rst)
    (clearEvent && !setEvent) |=> !flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear lost");
  property p_hold;
    @(posedge sys_clk) disable iff (rst)
    (!clearEvent && !setEvent) |=> $stable(flag);
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved with no event");

endmodule
`default_nettype wire

//--- core/flash_security_config_regs.sv
// Flash security, index and configuration registers behind an AHB-Lite slave.
// Assumes the flash reset sequence supplies the security byte read result and
// that the array read path reports each read with its real ECC outcome.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module flash_security_config_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reset sequence security byte load and backdoor unlock
  input  wire logic        secLoadValid,
  input  wire logic [7:0]  secLoadByte,
  input  wire logic        secLoadDoubleFault,
  input  wire logic        backdoorUnlock,
  // Array read events and command completion
  input  wire logic        arrayRead,
  input  wire logic        arraySingleFault,
  input  wire logic        arrayDoubleFault,
  input  wire logic        cmdComplete,
  // Outputs toward the rest of the controller
  output logic [2:0]       commandIndex,
  output logic [2:0]       eccIndex,
  output logic             eccResultUpdate,
  output logic             backdoorKeyEnabled,
  output logic             deviceSecured,
  output logic             cmdDoneIrq,
  output logic             doubleFaultIrq,
  output logic             singleFaultIrq
);

  typedef struct packed {
    flash_cfg_pkg::bus_req_type     req;
    flash_cfg_pkg::load_state_type  loadState;
    logic [7:0]                     security;
    logic [2:0]                     cmdIdx;
    logic [2:0]                     eccIdx;
    logic [7:0]                     cfg;
    logic [1:0]                     errCfg;
    logic [31:0]                    rdata;
    logic                           eccUpd;
  } regs_state_type;

  regs_state_type state_reg;
  regs_state_type state_next;

  logic cmdDoneFlag;
  logic dfFlag;
  logic sfFlag;
  logic wrStrobe;
  logic dfSet;
  logic sfSet;
  logic cmdDoneClr;
  logic dfClr;
  logic sfClr;
  logic [7:0] wbyte;

  assign wbyte    = hwdata[7:0];
  assign wrStrobe = state_reg.req.valid & state_reg.req.write;

  // Forced faults act on any read; ignore bit masks real and forced singles alike
  assign dfSet = arrayRead & (arrayDoubleFault | state_reg.cfg[flash_cfg_pkg::FORCE_DF_BIT]);
  assign sfSet = arrayRead & ~state_reg.cfg[flash_cfg_pkg::IGNORE_SF_BIT]
               & (arraySingleFault | state_reg.cfg[flash_cfg_pkg::FORCE_SF_BIT]);

  // Write one to the command done bit clears the flag
  assign cmdDoneClr = wrStrobe
    && state_reg.req.index == flash_cfg_pkg::MAIN_STATUS_IDX
    && wbyte[flash_cfg_pkg::CMD_DONE_BIT];
  assign dfClr = wrStrobe && state_reg.req.index == flash_cfg_pkg::ERR_STATUS_IDX
    && wbyte[flash_cfg_pkg::DF_BIT];
  assign sfClr = wrStrobe && state_reg.req.index == flash_cfg_pkg::ERR_STATUS_IDX
    && wbyte[flash_cfg_pkg::SF_BIT];

  flash_cfg_bit_flag cmdDoneUnit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setEvent   (cmdComplete),
    .clearEvent (cmdDoneClr),
    .enable     (state_reg.cfg[flash_cfg_pkg::CMD_DONE_IE_BIT]),
    .flag       (cmdDoneFlag),
    .request    (cmdDoneIrq)
  );

  flash_cfg_bit_flag dfUnit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setEvent   (dfSet),
    .clearEvent (dfClr),
    .enable     (state_reg.errCfg[flash_cfg_pkg::DF_BIT]),
    .flag       (dfFlag),
    .request    (doubleFaultIrq)
  );

  flash_cfg_bit_flag sfUnit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .setEvent   (sfSet),
    .clearEvent (sfClr),
    .enable     (state_reg.errCfg[flash_cfg_pkg::SF_BIT]),
    .flag       (sfFlag),
    .request    (singleFaultIrq)
  );

  always_comb begin
    state_next = state_reg;
    state_next.eccUpd = 1'b0;
    // Address phase capture
    state_next.req.valid = hsel && hready && htrans == flash_cfg_pkg::HTRANS_NONSEQ;
    if (hsel && hready) begin
      state_next.req.write = hwrite;
      state_next.req.index = haddr[9:2];
    end
    case (state_reg.loadState)
      flash_cfg_pkg::LOAD_WAIT: begin
        if (secLoadValid) begin
          state_next.loadState = flash_cfg_pkg::LOAD_DONE;
          if (secLoadDoubleFault) begin
            state_next.security = flash_cfg_pkg::SECURITY_FAULT_VALUE;
          end else begin
            state_next.security = secLoadByte;
          end
        end
      end
      flash_cfg_pkg::LOAD_RUN: begin
        state_next.loadState = flash_cfg_pkg::LOAD_DONE;
      end
      flash_cfg_pkg::LOAD_DONE: begin
        state_next.loadState = flash_cfg_pkg::LOAD_DONE;
      end
      default: begin
        state_next.loadState = flash_cfg_pkg::LOAD_WAIT;
      end
    endcase
    if (backdoorUnlock) begin
      state_next.security[flash_cfg_pkg::SEC_MSB:flash_cfg_pkg::SEC_LSB] =
        flash_cfg_pkg::UNSECURED_CODE;
    end
    // ECC results move on a real fault unless a force bit is set without its matching real fault
    if (arrayRead && (arraySingleFault || arrayDoubleFault)) begin
      state_next.eccUpd = 1'b1;
      if (state_reg.cfg[flash_cfg_pkg::FORCE_DF_BIT] && !arrayDoubleFault) begin
        state_next.eccUpd = 1'b0;
      end
      if (state_reg.cfg[flash_cfg_pkg::FORCE_SF_BIT] && !arraySingleFault) begin
        state_next.eccUpd = 1'b0;
      end
    end
    if (wrStrobe) begin
      case (state_reg.req.index)
        flash_cfg_pkg::CMD_INDEX_IDX: begin
          state_next.cmdIdx = wbyte[flash_cfg_pkg::CMD_INDEX_WIDTH-1:0];
        end
        flash_cfg_pkg::ECC_INDEX_IDX: begin
          state_next.eccIdx = wbyte[flash_cfg_pkg::ECC_INDEX_WIDTH-1:0];
        end
        flash_cfg_pkg::FLASH_CFG_IDX: begin
          // Force bits held until a zero is written
          state_next.cfg = wbyte & flash_cfg_pkg::FLASH_CFG_MASK;
        end
        flash_cfg_pkg::ERR_CFG_IDX: begin
          state_next.errCfg = wbyte[1:0];
        end
        default: begin
          // Security index falls here: writes have no effect
          state_next.cmdIdx = state_reg.cmdIdx;
        end
      endcase
    end
    // Read data registered during the address phase so it is ready in the data phase
    state_next.rdata = 32'h0;
    if (hsel && hready && htrans == flash_cfg_pkg::HTRANS_NONSEQ && !hwrite) begin
      case (haddr[9:2])
        flash_cfg_pkg::SECURITY_IDX:    state_next.rdata = {24'h0, state_next.security};
        flash_cfg_pkg::CMD_INDEX_IDX:   state_next.rdata = {29'h0, state_next.cmdIdx};
        flash_cfg_pkg::ECC_INDEX_IDX:   state_next.rdata = {29'h0, state_next.eccIdx};
        flash_cfg_pkg::FLASH_CFG_IDX:   state_next.rdata = {24'h0, state_next.cfg};
        flash_cfg_pkg::MAIN_STATUS_IDX: state_next.rdata = {24'h0, cmdDoneFlag, 7'h0};
        flash_cfg_pkg::ERR_CFG_IDX:     state_next.rdata = {30'h0, state_next.errCfg};
        flash_cfg_pkg::ERR_STATUS_IDX:  state_next.rdata = {30'h0, dfFlag, sfFlag};
        default:                        state_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg           <= '0;
      state_reg.loadState <= flash_cfg_pkg::LOAD_WAIT;
      state_reg.security  <= flash_cfg_pkg::SECURITY_RESET;
      state_reg.cfg       <= flash_cfg_pkg::FLASH_CFG_RESET;
      state_reg.errCfg    <= flash_cfg_pkg::ERR_CFG_RESET[1:0];
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata          = state_reg.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign commandIndex    = state_reg.cmdIdx;
  assign eccIndex        = state_reg.eccIdx;
  assign eccResultUpdate = state_reg.eccUpd;
  assign backdoorKeyEnabled =
    state_reg.security[flash_cfg_pkg::KEY_EN_MSB:flash_cfg_pkg::KEY_EN_LSB]
    == flash_cfg_pkg::KEY_ENABLED_CODE;
  assign deviceSecured =
    state_reg.security[flash_cfg_pkg::SEC_MSB:flash_cfg_pkg::SEC_LSB]
    != flash_cfg_pkg::UNSECURED_CODE;

  // Assertions
  // One load cycle of the reset sequence, with no unlock landing on top of it
  sequence s_load_step;
    state_reg.loadState == flash_cfg_pkg::LOAD_WAIT && secLoadValid && !backdoorUnlock;
  endsequence
  sequence s_cfg_untouched;
    !(wrStrobe && state_reg.req.index == flash_cfg_pkg::FLASH_CFG_IDX);
  endsequence
  property p_sec_ro;
    @(posedge sys_clk) disable iff (rst)
    (state_reg.loadState == flash_cfg_pkg::LOAD_DONE && !backdoorUnlock)
    |=> $stable(state_reg.security);
  endproperty
  a_sec_ro: assert property (p_sec_ro) else $error("security changed");
  property p_sec_load;
    @(posedge sys_clk) disable iff (rst)
    s_load_step ##0 !secLoadDoubleFault |=> state_reg.security == $past(secLoadByte);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security byte not loaded");
  property p_sec_dbl;
    @(posedge sys_clk) disable iff (rst)
    s_load_step ##0 secLoadDoubleFault
    |=> state_reg.security == 8'hff && !backdoorKeyEnabled && deviceSecured;
  endproperty
  a_sec_dbl: assert property (p_sec_dbl) else $error("fault load not secured");
  property p_key;
    @(posedge sys_clk) disable iff (rst)
    backdoorKeyEnabled == (state_reg.security[7:6] == 2'h2);
  endproperty
  a_key: assert property (p_key) else $error("key decode");
  property p_secured;
    @(posedge sys_clk) disable iff (rst)
    deviceSecured == (state_reg.security[1:0] != 2'h2);
  endproperty
  a_secured: assert property (p_secured) else $error("security decode");
  property p_unlock;
    @(posedge sys_clk) disable iff (rst)
    backdoorUnlock |=> !deviceSecured;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");
  property p_cfg_zero;
    @(posedge sys_clk) disable iff (rst)
    (state_reg.cfg & 8'h6c) == 8'h00;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("cfg reserved bits set");
  property p_force_df;
    @(posedge sys_clk) disable iff (rst)
    (arrayRead && state_reg.cfg[1]) |=> dfFlag;
  endproperty
  a_force_df: assert property (p_force_df) else $error("forced double fault missed");
  property p_force_sf;
    @(posedge sys_clk) disable iff (rst)
    (arrayRead && state_reg.cfg[0] && !state_reg.cfg[4]) |=> sfFlag;
  endproperty
  a_force_sf: assert property (p_force_sf) else $error("forced single fault missed");
  property p_ignore_sf;
    @(posedge sys_clk) disable iff (rst)
    (state_reg.cfg[4] && !sfFlag && !wrStrobe) |=> !sfFlag;
  endproperty
  a_ignore_sf: assert property (p_ignore_sf) else $error("single fault not ignored");
  property p_no_upd;
    @(posedge sys_clk) disable iff (rst)
    (arrayRead && state_reg.cfg[1] && !arrayDoubleFault) |=> !eccResultUpdate;
  endproperty
  a_no_upd: assert property (p_no_upd) else $error("ecc updated under forced fault");
  property p_no_upd_sf;
    @(posedge sys_clk) disable iff (rst)
    (arrayRead && state_reg.cfg[0] && !arraySingleFault) |=> !eccResultUpdate;
  endproperty
  a_no_upd_sf: assert property (p_no_upd_sf) else $error("ecc updated under forced single");
  property p_upd_real;
    @(posedge sys_clk) disable iff (rst)
    (arrayRead && (arraySingleFault || arrayDoubleFault) && state_reg.cfg[1:0] == 2'h0)
    |=> eccResultUpdate;
  endproperty
  a_upd_real: assert property (p_upd_real) else $error("ecc update missed");
  property p_force_hold;
    @(posedge sys_clk) disable iff (rst)
    s_cfg_untouched |=> $stable(state_reg.cfg);
  endproperty
  a_force_hold: assert property (p_force_hold) else $error("configuration moved");
  property p_force_clear;
    @(posedge sys_clk) disable iff (rst)
    (wrStrobe && state_reg.req.index == 8'h04 && !hwdata[1]) |=> !state_reg.cfg[1];
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("force bit not cleared");
  property p_cmd_idx;
    @(posedge sys_clk) disable iff (rst)
    (wrStrobe && state_reg.req.index == 8'h02) |=> commandIndex == $past(hwdata[2:0]);
  endproperty
  a_cmd_idx: assert property (p_cmd_idx) else $error("command index write lost");
  property p_ecc_idx;
    @(posedge sys_clk) disable iff (rst)
    (wrStrobe && state_reg.req.index == 8'h03) |=> eccIndex == $past(hwdata[2:0]);
  endproperty
  a_ecc_idx: assert property (p_ecc_idx) else $error("ecc index write lost");
  property p_cmd_irq;
    @(posedge sys_clk) disable iff (rst)
    cmdDoneIrq == (cmdDoneFlag && state_reg.cfg[7]);
  endproperty
  a_cmd_irq: assert property (p_cmd_irq) else $error("command done request wrong");
  property p_df_irq;
    @(posedge sys_clk) disable iff (rst)
    doubleFaultIrq == (dfFlag && state_reg.errCfg[1]);
  endproperty
  a_df_irq: assert property (p_df_irq) else $error("double fault request wrong");
  // Read data stands only in the data phase of a read
  property p_rd_idle;
    @(posedge sys_clk) disable iff (rst)
    !(hsel && hready && htrans == 2'h2 && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");

endmodule
`default_nettype wire

//--- verification/flash_ahb_master.sv
// Processor-side bus master model: single word transfers over AHB-Lite.
// Assumes the one slave's hreadyout is fed back as hready; tasks are called from the bench
// just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module flash_ahb_master (
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = flash_cfg_pkg::HSIZE_WORD;
    hwdata = 32'h0;
  end

  // Address phase held until hready, data phase held until hready, read data taken there
  task automatic busXfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                         output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= flash_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= flash_cfg_pkg::HSIZE_WORD;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdata = hrdata;
    // Stale write data is inverted so nothing can lean on it after the transfer
    hwdata <= ~wdata;
  endtask
endmodule
`default_nettype wire

//--- verification/test_flash_security_config_regs.sv
// Self-checking bench for the flash security, index and configuration registers.
// Assumes the bus master model drives the AHB-Lite side and the bench drives the event inputs.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module test_flash_security_config_regs;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, secLoadValid, secLoadDoubleFault;
  logic backdoorUnlock, arrayRead, arraySingleFault, arrayDoubleFault, cmdComplete;
  logic eccResultUpdate, backdoorKeyEnabled, deviceSecured, cmdDoneIrq, doubleFaultIrq;
  logic singleFaultIrq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, commandIndex, eccIndex;
  logic [7:0]  secLoadByte;
  int          miscompares = 0;
  int          nChecks = 0;
  int          cycleCount = 0;

  flash_security_config_regs i_flash_security_config_regs (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .secLoadValid(secLoadValid), .secLoadByte(secLoadByte),
    .secLoadDoubleFault(secLoadDoubleFault), .backdoorUnlock(backdoorUnlock),
    .arrayRead(arrayRead), .arraySingleFault(arraySingleFault),
    .arrayDoubleFault(arrayDoubleFault), .cmdComplete(cmdComplete),
    .commandIndex(commandIndex), .eccIndex(eccIndex), .eccResultUpdate(eccResultUpdate),
    .backdoorKeyEnabled(backdoorKeyEnabled), .deviceSecured(deviceSecured),
    .cmdDoneIrq(cmdDoneIrq), .doubleFaultIrq(doubleFaultIrq),
    .singleFaultIrq(singleFaultIrq));

  flash_ahb_master i_flash_ahb_master (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang anywhere counts against the run instead of stalling it
  always @(posedge sys_clk) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      miscompares++;
      giveVerdict();
    end
  end

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    i_flash_ahb_master.busXfer(addr, 1'b1, data, unused);
    #1;
  endtask

  task automatic rdChk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    i_flash_ahb_master.busXfer(addr, 1'b0, 32'h0, got);
    `CHECK("read data", exp, got)
    #1;
  endtask

  // One-cycle pulse on an event input; returns once the taking edge has landed
  task automatic pulse(input int which);
    @(posedge sys_clk);
    case (which)
      0: secLoadValid <= 1'b1;
      1: backdoorUnlock <= 1'b1;
      2: arrayRead <= 1'b1;
      default: cmdComplete <= 1'b1;
    endcase
    @(posedge sys_clk);
    {secLoadValid, backdoorUnlock, arrayRead, cmdComplete} <= 4'h0;
    #1;
  endtask

  task automatic applyReset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic testSecurity;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      applyReset();
      secLoadByte <= {p, 4'hf, p};
      pulse(0);
      rdChk(32'h04, {24'h0, p, 4'hf, p});
      `CHECK("key enabled", 1'(p == 2'h2), backdoorKeyEnabled)
      `CHECK("secured", 1'(p != 2'h2), deviceSecured)
      wr(32'h04, 32'h0);
      rdChk(32'h04, {24'h0, p, 4'hf, p});
    end
    applyReset();
    secLoadByte <= 8'hbe;
    secLoadDoubleFault <= 1'b1;
    pulse(0);
    secLoadDoubleFault <= 1'b0;
    rdChk(32'h04, 32'h000000ff);
    applyReset();
    secLoadByte <= 8'h7d;
    pulse(0);
    pulse(1);
    rdChk(32'h04, 32'h0000007e);
    `CHECK("secured", 1'b0, deviceSecured)
    $display("test security done");
  endtask

  task automatic testIndexConfig;
    wr(32'h08, 32'hffffffff);
    rdChk(32'h08, 32'h7);
    wr(32'h08, 32'h5);
    `CHECK("command index", 3'h5, commandIndex)
    wr(32'h0c, 32'hffffffff);
    rdChk(32'h0c, 32'h7);
    wr(32'h0c, 32'h2);
    `CHECK("ecc index", 3'h2, eccIndex)
    wr(32'h10, 32'hffffffff);
    rdChk(32'h10, 32'h93);
    wr(32'h10, 32'h0);
    rdChk(32'h10, 32'h0);
    rdChk(32'h40, 32'h0);
    `CHECK("response", 1'b0, hresp)
    `CHECK("ready", 1'b1, hreadyout)
    $display("test index and configuration done");
  endtask

  task automatic testCmdDone;
    wr(32'h10, 32'h80);
    pulse(3);
    `CHECK("done irq", 1'b1, cmdDoneIrq)
    rdChk(32'h18, 32'h80);
    wr(32'h18, 32'h80);
    `CHECK("done irq", 1'b0, cmdDoneIrq)
    wr(32'h10, 32'h0);
    pulse(3);
    `CHECK("done irq", 1'b0, cmdDoneIrq)
    rdChk(32'h18, 32'h80);
    $display("test command done flag done");
  endtask

  task automatic testFaults;
    wr(32'h1c, 32'h3);
    wr(32'h10, 32'h02);
    pulse(2);
    `CHECK("double irq", 1'b1, doubleFaultIrq)
    `CHECK("ecc update", 1'b0, eccResultUpdate)
    rdChk(32'h10, 32'h02);
    wr(32'h20, 32'h3);
    `CHECK("double irq", 1'b0, doubleFaultIrq)
    arrayDoubleFault <= 1'b1;
    pulse(2);
    arrayDoubleFault <= 1'b0;
    `CHECK("ecc update", 1'b1, eccResultUpdate)
    wr(32'h20, 32'h3);
    wr(32'h10, 32'h01);
    pulse(2);
    `CHECK("single irq", 1'b1, singleFaultIrq)
    `CHECK("ecc update", 1'b0, eccResultUpdate)
    wr(32'h20, 32'h3);
    arraySingleFault <= 1'b1;
    pulse(2);
    `CHECK("ecc update", 1'b1, eccResultUpdate)
    wr(32'h20, 32'h3);
    wr(32'h10, 32'h11);
    pulse(2);
    `CHECK("single irq", 1'b0, singleFaultIrq)
    wr(32'h10, 32'h0);
    pulse(2);
    arraySingleFault <= 1'b0;
    `CHECK("single irq", 1'b1, singleFaultIrq)
    wr(32'h20, 32'h3);
    pulse(2);
    `CHECK("double irq", 1'b0, doubleFaultIrq)
    `CHECK("single irq", 1'b0, singleFaultIrq)
    wr(32'h1c, 32'h0);
    wr(32'h10, 32'h02);
    pulse(2);
    `CHECK("double irq", 1'b0, doubleFaultIrq)
    rdChk(32'h20, 32'h2);
    wr(32'h10, 32'h0);
    $display("test fault forcing done");
  endtask

  initial begin
    rst = 1'b1;
    {secLoadValid, secLoadDoubleFault, backdoorUnlock, arrayRead} = 4'h0;
    {arraySingleFault, arrayDoubleFault, cmdComplete} = 3'h0;
    secLoadByte = 8'h0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHECK("secured at reset", 1'b1, deviceSecured)
    rdChk(32'h04, 32'h000000ff);
    testSecurity();
    testIndexConfig();
    testCmdDone();
    testFaults();
    giveVerdict();
  end
endmodule
`default_nettype wire
